// ---- core/swk_serial_port.sv ----
// serial port pin control, modes, break send and sleep wake-up
`timescale 1ns/1ps
// -----------------------------------------------------------------
// What this block does
// - pins belong to the port only while serial_port_enable is set
// - port logic itself turns the data pin between in and out
// - async full duplex, sync master and slave, clock polarity
// - in sleep the baud generator halts; rx_enable is not gated by sleep_mode
// - wake_up_enable arms wake-up, only in asynchronous mode
// - while wake_up_enable is set normal reception is off
// - falling edge on the receive line is the wake-up event
// - wake-up event sets the receive interrupt flag
// - reading the receive data register clears the wake flag
// - first rising edge after wake clears wake_up_enable
// - any early rising edge ends wake-up early
// - async transmitter sends a 12 bit-time break
// -----------------------------------------------------------------
module swk_serial_port
    import swk_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sleep_mode,
    input  wire logic        receive_data_line,
    output logic             receive_data_line_drv,
    output logic             receive_data_line_oe_n,
    input  wire logic        transmit_clock_line,
    output logic             transmit_clock_line_drv,
    output logic             transmit_clock_line_oe_n,
    input  wire logic        ser_dout,
    input  wire logic [7:0]  rx_byte,
    output logic             ser_rx,
    output logic             ser_clk,
    output logic             rx_enable,
    output logic             baud_tick,
    output logic             receive_interrupt_flag,
    output logic             irq
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  txc;
        logic [7:0]  rxc;
        logic [7:0]  bdc;
        logic [7:0]  div;
        logic [7:0]  mask;
        logic [7:0]  pdir;
        logic [1:0]  ists;
        logic        ack;
        logic [31:0] rdata;
        swk_wake_e   wk;
        swk_brk_e    bk;
        logic [3:0]  bcnt;
        logic        ckph;
    } swk_state_s;

    localparam swk_state_s RST_STATE = '{
        txc:   RST_TXC,
        rxc:   RST_RXC,
        bdc:   RST_BDC,
        div:   RST_DIV,
        mask:  RST_MASK,
        pdir:  RST_PDIR,
        ists:  2'h0,
        ack:   1'b0,
        rdata: 32'h0000_0000,
        wk:    WK_IDLE,
        bk:    BK_IDLE,
        bcnt:  4'h0,
        ckph:  1'b0
    };

    swk_state_s q;
    swk_state_s d;

    logic acc;
    logic done_rd;
    logic done_wr;
    logic port_en;
    logic async_m;
    logic wake_en;
    logic pol;
    logic txen;
    logic master;
    logic brk_on;
    logic wake_on;
    logic set_wake;
    logic tick;
    logic rx_lvl;
    logic rx_rise;
    logic rx_fall;
    logic ck_lvl;

    // -------------------------------------------------------------
    // pin synchronisers and bit timer
    // -------------------------------------------------------------
    swk_line_sync u_rx_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .pin     (receive_data_line),
        .level   (rx_lvl),
        .rise    (rx_rise),
        .fall    (rx_fall)
    );
    swk_line_sync u_ck_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .pin     (transmit_clock_line),
        .level   (ck_lvl),
        .rise    (),
        .fall    ()
    );
    swk_tick u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .run     (port_en & ~sleep_mode),
        .div     (q.div),
        .tick    (tick)
    );

    // -------------------------------------------------------------
    // decoded controls
    // -------------------------------------------------------------
    assign port_en = q.rxc[RXC_PORT];
    assign async_m = ~q.txc[TXC_SYNC];
    assign wake_en = q.bdc[BDC_WAKE];
    assign pol     = q.bdc[BDC_POL];
    assign txen    = q.txc[TXC_TXEN];
    assign master  = q.txc[TXC_MASTER];
    assign brk_on  = (q.bk == BK_SEND);
    assign wake_on = wake_en & async_m & port_en;
    assign acc     = (avs_read | avs_write) & ~q.ack;
    assign done_rd = avs_read & q.ack;
    assign done_wr = avs_write & q.ack;
    assign set_wake = (q.wk == WK_ARMED) & wake_on & rx_fall;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        d     = q;
        d.ack = acc;
        // read data captured in the wait cycle
        if (acc && avs_read) begin
            if (avs_address == OFS_TXC) begin
                d.rdata = {24'h000000, q.txc};
            end else if (avs_address == OFS_RXC) begin
                d.rdata = {24'h000000, q.rxc};
            end else if (avs_address == OFS_BDC) begin
                d.rdata = {24'h000000, q.bdc};
            end else if (avs_address == OFS_DIV) begin
                d.rdata = {24'h000000, q.div};
            end else if (avs_address == OFS_RXD) begin
                d.rdata = {24'h000000, rx_byte};
            end else if (avs_address == OFS_ISTS) begin
                d.rdata = {30'h0, q.ists};
            end else if (avs_address == OFS_MASK) begin
                d.rdata = {24'h000000, q.mask};
            end else if (avs_address == OFS_PDIR) begin
                d.rdata = {24'h000000, q.pdir};
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end
        // writes take effect when waitrequest is low
        if (done_wr) begin
            if (avs_address == OFS_TXC) begin
                d.txc = avs_writedata[7:0];
            end else if (avs_address == OFS_RXC) begin
                d.rxc = avs_writedata[7:0];
            end else if (avs_address == OFS_BDC) begin
                d.bdc = avs_writedata[7:0];
            end else if (avs_address == OFS_DIV) begin
                d.div = avs_writedata[7:0];
            end else if (avs_address == OFS_MASK) begin
                d.mask = avs_writedata[7:0];
            end else if (avs_address == OFS_PDIR) begin
                d.pdir = avs_writedata[7:0];
            end
        end
        // read side effects, hardware sets below win
        if (done_rd) begin
            if (avs_address == OFS_ISTS) begin
                d.ists = 2'h0;
            end else if (avs_address == OFS_RXD) begin
                d.ists[IRQ_WAKE] = 1'b0;
            end
        end
        // wake-up detector, independent of the bit timer
        case (q.wk)
            WK_IDLE: begin
                if (wake_on) begin
                    d.wk = WK_ARMED;
                end
            end
            WK_ARMED: begin
                if (!wake_on) begin
                    d.wk = WK_IDLE;
                end else if (rx_fall) begin
                    d.wk = WK_LOW;
                    d.ists[IRQ_WAKE] = 1'b1;
                end
            end
            WK_LOW: begin
                if (!wake_en) begin
                    d.wk = WK_IDLE;
                end else if (rx_rise) begin
                    d.bdc[BDC_WAKE] = 1'b0;
                    d.wk = WK_IDLE;
                end
            end
            default: begin
                d.wk = WK_IDLE;
            end
        endcase
        // break transmitter
        case (q.bk)
            BK_IDLE: begin
                if (q.txc[TXC_BRK] && async_m && port_en && txen && tick) begin
                    d.bk   = BK_SEND;
                    d.bcnt = 4'h0;
                end
            end
            BK_SEND: begin
                if (!(async_m && port_en)) begin
                    d.bk = BK_IDLE;
                end else if (tick) begin
                    if (q.bcnt == BREAK_BITS - 4'h1) begin
                        d.bk             = BK_IDLE;
                        d.txc[TXC_BRK]   = 1'b0;
                        d.ists[IRQ_BRK]  = 1'b1;
                    end else begin
                        d.bcnt = q.bcnt + 4'h1;
                    end
                end
            end
            default: begin
                d.bk = BK_IDLE;
            end
        endcase
        // synchronous master clock phase
        if (port_en && !async_m && master && txen) begin
            if (tick) begin
                d.ckph = ~q.ckph;
            end
        end else begin
            d.ckph = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // pin steering
    // -------------------------------------------------------------
    always_comb begin
        if (!port_en) begin
            transmit_clock_line_oe_n = q.pdir[PDIR_TX];
            transmit_clock_line_drv  = 1'b1;
            receive_data_line_oe_n   = q.pdir[PDIR_RX];
            receive_data_line_drv    = 1'b1;
        end else if (async_m) begin
            transmit_clock_line_oe_n = 1'b0;
            transmit_clock_line_drv  = brk_on ? 1'b0 : ser_dout;
            receive_data_line_oe_n   = 1'b1;
            receive_data_line_drv    = 1'b1;
        end else begin
            transmit_clock_line_oe_n = ~master;
            transmit_clock_line_drv  = q.ckph ^ pol;
            receive_data_line_oe_n   = ~txen;
            receive_data_line_drv    = ser_dout;
        end
    end

    assign ser_rx    = rx_lvl;
    assign ser_clk   = master ? q.ckph : (ck_lvl ^ pol);
    assign rx_enable = port_en & q.rxc[RXC_CREN] & ~wake_en;
    assign baud_tick = tick;
    assign avs_waitrequest = acc;
    assign avs_readdata    = q.rdata;
    assign receive_interrupt_flag = q.ists[IRQ_WAKE];
    assign irq = |(q.ists & q.mask[1:0]);
    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        ce && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_wake_edge;
        ce && q.wk == WK_ARMED && wake_on && rx_fall;
    endsequence
    property p_bus_answer;
        s_req |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest held longer than one cycle");
    property p_wake_flag;
        s_wake_edge |=> receive_interrupt_flag && q.wk == WK_LOW;
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake edge did not set the flag");
    property p_wue_clear;
        ce && q.wk == WK_LOW && wake_en && rx_rise
            |=> !q.bdc[BDC_WAKE] && q.wk == WK_IDLE;
    endproperty
    a_wue_clear: assert property (p_wue_clear)
        else $error("rising edge did not end wake-up");
    property p_rd_clear;
        ce && done_rd && avs_address == OFS_RXD && !set_wake
            |=> !receive_interrupt_flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("data read did not clear wake flag");
    property p_no_rx;
        wake_en |-> !rx_enable;
    endproperty
    a_no_rx: assert property (p_no_rx)
        else $error("reception enabled during wake-up");
    property p_sync_disarm;
        ce && !async_m && q.wk == WK_ARMED |=> q.wk == WK_IDLE;
    endproperty
    a_sync_disarm: assert property (p_sync_disarm)
        else $error("wake-up armed in synchronous mode");
    property p_release;
        !port_en |-> transmit_clock_line_oe_n == q.pdir[PDIR_TX]
               && receive_data_line_oe_n == q.pdir[PDIR_RX];
    endproperty
    a_release: assert property (p_release)
        else $error("pins driven while port disabled");
    property p_brk_low;
        brk_on && async_m && port_en
            |-> !transmit_clock_line_drv && !transmit_clock_line_oe_n;
    endproperty
    a_brk_low: assert property (p_brk_low)
        else $error("break not driven low");
    property p_brk_end;
        ce && brk_on && async_m && port_en && tick && q.bcnt == 4'hB
            |=> !brk_on && q.ists[IRQ_BRK] && !q.txc[TXC_BRK];
    endproperty
    a_brk_end: assert property (p_brk_end)
        else $error("break did not end after twelve bits");
endmodule : swk_serial_port

// ---- core/swk_pkg.sv ----
// shared constants and types of the serial port wake-up block
package swk_pkg;
    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [4:0] OFS_TXC  = 5'h00;
    localparam logic [4:0] OFS_RXC  = 5'h04;
    localparam logic [4:0] OFS_BDC  = 5'h08;
    localparam logic [4:0] OFS_DIV  = 5'h0C;
    localparam logic [4:0] OFS_RXD  = 5'h10;
    localparam logic [4:0] OFS_ISTS = 5'h14;
    localparam logic [4:0] OFS_MASK = 5'h18;
    localparam logic [4:0] OFS_PDIR = 5'h1C;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int TXC_MASTER = 7;
    localparam int TXC_TXEN   = 5;
    localparam int TXC_SYNC   = 4;
    localparam int TXC_BRK    = 3;
    localparam int RXC_PORT   = 7;
    localparam int RXC_CREN   = 4;
    localparam int BDC_POL    = 4;
    localparam int BDC_WAKE   = 1;
    localparam int IRQ_WAKE   = 0;
    localparam int IRQ_BRK    = 1;
    localparam int PDIR_TX    = 0;
    localparam int PDIR_RX    = 1;
    // -------------------------------------------------------------
    // reset values and counts
    // -------------------------------------------------------------
    localparam logic [7:0] RST_TXC  = 8'h00;
    localparam logic [7:0] RST_RXC  = 8'h00;
    localparam logic [7:0] RST_BDC  = 8'h00;
    localparam logic [7:0] RST_DIV  = 8'h0F;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_PDIR = 8'h03;
    localparam logic [3:0] BREAK_BITS = 4'hC;
    // -------------------------------------------------------------
    // state encodings
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        WK_IDLE  = 3'b001,
        WK_ARMED = 3'b010,
        WK_LOW   = 3'b100
    } swk_wake_e;
    typedef enum logic [1:0] {
        BK_IDLE = 2'b01,
        BK_SEND = 2'b10
    } swk_brk_e;
endpackage : swk_pkg

// ---- core/swk_line_sync.sv ----
// three-flop pin synchroniser with edge pulses
`timescale 1ns/1ps
module swk_line_sync (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } swk_sync_s;

    swk_sync_s q;
    swk_sync_s d;

    always_comb begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= 3'b111;
        end else if (ce) begin
            q <= d;
        end
    end

    // edges from the second and third stage only, no baud clock used
    assign level = q.s2;
    assign rise  = q.s2 & ~q.s3;
    assign fall  = ~q.s2 & q.s3;
endmodule : swk_line_sync

// ---- core/swk_tick.sv ----
// bit-time tick generator, divides by div plus one
`timescale 1ns/1ps
module swk_tick (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [7:0] div,
    output logic            tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } swk_tick_s;

    swk_tick_s q;
    swk_tick_s d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = 8'h00;
        end else if (q.cnt >= div) begin
            d.cnt  = 8'h00;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= 9'h000;
        end else if (ce) begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : swk_tick

// ---- bench/swk_line_partner.sv ----
// far-side node model: drives the receive line, watches the transmit line
`timescale 1ns/1ps
module swk_line_partner (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       go,
    input  wire logic [7:0] low_len,
    input  wire logic       data_oe_n,
    input  wire logic       data_drv,
    input  wire logic       clk_oe_n,
    input  wire logic       clk_drv,
    output logic            data_line,
    output logic            clock_line,
    output logic [7:0]      low_run
);
    logic       line_q;
    logic [7:0] cnt_q;
    logic [7:0] run_q;
    // ---------------------------------------------------------
    // all-zero wake character, then long idle high
    // ---------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            line_q <= 1'b1;
            cnt_q  <= 8'h00;
        end else if (go) begin
            line_q <= 1'b0;
            cnt_q  <= low_len;
        end else if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            cnt_q  <= 8'h00;
            line_q <= 1'b1;
        end
    end
    // ---------------------------------------------------------
    // pin resolution, clock line pulled up when released, data line then driven by line_q
    // ---------------------------------------------------------
    assign data_line  = !data_oe_n ? data_drv : line_q;
    assign clock_line = !clk_oe_n ? clk_drv : 1'b1;
    // length of the last low run on the transmit line
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            run_q   <= 8'h00;
            low_run <= 8'h00;
        end else if (!clock_line) begin
            run_q <= run_q + 8'h01;
        end else if (run_q != 8'h00) begin
            low_run <= run_q;
            run_q   <= 8'h00;
        end
    end
endmodule : swk_line_partner

// ---- bench/test_swk_serial_port.sv ----
// self-checking testbench of the serial port wake-up block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); end end
module test_swk_serial_port
    import swk_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sleep_mode = 1'b0;
    logic        ce = 1'b1;
    logic        ser_dout = 1'b0;
    logic [7:0]  rx_byte = 8'h00;
    logic        go = 1'b0;
    logic [7:0]  low_len = 8'h00;
    logic        rxl, rxl_drv, rxl_oe_n, txl, txl_drv, txl_oe_n;
    logic        ser_rx, ser_clk, rx_enable, baud_tick, rflag, irq;
    logic [7:0]  low_run;
    logic [7:0]  q;
    logic        p;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    always #25 sys_clk = ~sys_clk;
    swk_serial_port uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sleep_mode(sleep_mode), .receive_data_line(rxl),
        .receive_data_line_drv(rxl_drv), .receive_data_line_oe_n(rxl_oe_n),
        .transmit_clock_line(txl), .transmit_clock_line_drv(txl_drv),
        .transmit_clock_line_oe_n(txl_oe_n), .ser_dout(ser_dout),
        .rx_byte(rx_byte), .ser_rx(ser_rx), .ser_clk(ser_clk),
        .rx_enable(rx_enable), .baud_tick(baud_tick),
        .receive_interrupt_flag(rflag), .irq(irq));
    swk_line_partner peer (.sys_clk(sys_clk), .nrst(nrst), .go(go),
        .low_len(low_len), .data_oe_n(rxl_oe_n), .data_drv(rxl_drv),
        .clk_oe_n(txl_oe_n), .clk_drv(txl_drv), .data_line(rxl),
        .clock_line(txl), .low_run(low_run));
    // ---------------------------------------------------------
    // bus and helper tasks
    // ---------------------------------------------------------
    task automatic xfer(input logic [4:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] r);
        logic wt;
        int   k;
        wt = 1'b1;
        k = 0;
        r = 8'h00;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h000000, d};
        while (wt && k < 50) begin
            @(posedge sys_clk);
            wt = avs_waitrequest;
            r = avs_readdata[7:0];
            k++;
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        `CHK(wt, 1'b0)
    endtask : xfer
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(a, 1'b1, d, r);
    endtask : wr
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc
    task automatic send_low(input logic [7:0] l);
        @(posedge sys_clk);
        go      <= 1'b1;
        low_len <= l;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask : send_low
    task automatic complete_run;
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic t_reset;
        xfer(OFS_TXC, 1'b0, 8'h00, q); `CHK(q, RST_TXC)
        xfer(OFS_RXC, 1'b0, 8'h00, q); `CHK(q, RST_RXC)
        xfer(OFS_BDC, 1'b0, 8'h00, q); `CHK(q, RST_BDC)
        xfer(OFS_DIV, 1'b0, 8'h00, q); `CHK(q, RST_DIV)
        xfer(OFS_MASK, 1'b0, 8'h00, q); `CHK(q, RST_MASK)
        xfer(OFS_PDIR, 1'b0, 8'h00, q); `CHK(q, RST_PDIR)
        wr(5'h13, 8'hFF);
        xfer(5'h13, 1'b0, 8'h00, q); `CHK(q, 8'h00)
        wr(OFS_TXC, 8'hB0);
        cyc(1);
        `CHK({txl_oe_n, rxl_oe_n}, 2'b11)
        wr(OFS_TXC, 8'h00);
    endtask : t_reset
    task automatic t_sync;
        wr(OFS_DIV, 8'h01);
        wr(OFS_PDIR, 8'h02);
        wr(OFS_RXC, 8'h80);
        wr(OFS_TXC, 8'hB0);
        cyc(1);
        `CHK({txl_oe_n, rxl_oe_n}, 2'b00)
        @(posedge sys_clk) ser_dout <= 1'b1;
        cyc(1); `CHK(rxl_drv, 1'b1)
        @(posedge sys_clk) ser_dout <= 1'b0;
        cyc(0);
        q = 8'h00;
        for (n = 0; n < 8; n++) begin
            p = txl_drv;
            cyc(1);
            if (txl_drv !== p) q = q + 8'h01;
        end
        `CHK(rxl_drv, 1'b0)
        `CHK(ser_rx, 1'b0)
        `CHK(q, 8'h04)
        @(posedge sys_clk) ce <= 1'b0;
        cyc(1);
        q = 8'h00;
        for (n = 0; n < 8; n++) begin
            p = txl_drv;
            cyc(1);
            if (txl_drv !== p) q = q + 8'h01;
        end
        `CHK(q, 8'h00)
        @(posedge sys_clk) ce <= 1'b1;
        wr(OFS_PDIR, 8'h03);
        for (n = 0; n < 2; n++) begin
            wr(OFS_BDC, n[0] ? 8'h10 : 8'h00);
            wr(OFS_TXC, 8'h30);
            cyc(4);
            `CHK(txl_oe_n, 1'b1)
            `CHK(ser_clk, ~n[0])
        end
        wr(OFS_BDC, 8'h00);
        wr(OFS_TXC, 8'h00);
        wr(OFS_PDIR, 8'h02);
    endtask : t_sync
    task automatic t_wake;
        ser_dout <= 1'b1;
        wr(OFS_RXC, 8'h90);
        wr(OFS_MASK, 8'h03);
        wr(OFS_BDC, 8'h02);
        cyc(2); `CHK(rx_enable, 1'b0)
        send_low(8'd40);
        cyc(8); `CHK(rflag, 1'b1)
        `CHK(irq, 1'b1)
        xfer(OFS_BDC, 1'b0, 8'h00, q); `CHK(q, 8'h02)
        cyc(40);
        xfer(OFS_BDC, 1'b0, 8'h00, q); `CHK(q, 8'h00)
        `CHK(rx_enable, 1'b1)
        `CHK(rflag, 1'b1)
        rx_byte <= 8'hA5;
        xfer(OFS_RXD, 1'b0, 8'h00, q); `CHK(q, 8'hA5)
        cyc(1); `CHK(rflag, 1'b0)
        `CHK(irq, 1'b0)
        wr(OFS_BDC, 8'h02);
        wr(OFS_TXC, 8'h90);
        send_low(8'd20);
        cyc(30); `CHK(rflag, 1'b0)
        wr(OFS_BDC, 8'h00);
        wr(OFS_TXC, 8'h00);
    endtask : t_wake
    task automatic t_sleep;
        sleep_mode <= 1'b1;
        q = 8'h00;
        for (n = 0; n < 20; n++) begin
            cyc(1);
            if (baud_tick) q = q + 8'h01;
        end
        `CHK(q, 8'h00)
        wr(OFS_BDC, 8'h02);
        send_low(8'd8);
        cyc(8); `CHK(rflag, 1'b1)
        cyc(6); `CHK(rx_enable, 1'b1)
        xfer(OFS_BDC, 1'b0, 8'h00, q); `CHK(q, 8'h00)
        xfer(OFS_RXD, 1'b0, 8'h00, q);
        sleep_mode <= 1'b0;
        q = 8'h00;
        for (n = 0; n < 20; n++) begin
            cyc(1);
            if (baud_tick) q = q + 8'h01;
        end
        `CHK(q, 8'h0A)
    endtask : t_sleep
    task automatic t_break;
        wr(OFS_TXC, 8'h28);
        cyc(60);
        `CHK(low_run, 8'd24)
        `CHK(irq, 1'b1)
        xfer(OFS_TXC, 1'b0, 8'h00, q); `CHK(q, 8'h20)
        xfer(OFS_ISTS, 1'b0, 8'h00, q); `CHK(q, 8'h02)
        xfer(OFS_ISTS, 1'b0, 8'h00, q); `CHK(q, 8'h00)
        `CHK(irq, 1'b0)
    endtask : t_break
    // ---------------------------------------------------------
    // main sequence and timeout
    // ---------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            $display("ERROR %0t timeout", $time);
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_sync();
        t_wake();
        t_sleep();
        t_break();
        complete_run();
    end
endmodule : test_swk_serial_port
